// ### core/uart_rx_status.sv
// serial receiver with fifo, receive line status flags and ahb-lite slave
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "uart_rx_regs.svh"

module uart_rx_status
#(
  parameter int DEPTH = `RX_FIFO_DEPTH
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rxd,
  output logic             rx_data_available
);
  import uart_rx_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // rxd comes from a pin: two flops before anything looks at it
  logic sync1_q;
  logic rxd_s_q;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      sync1_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end
    else
    begin
      sync1_q <= rxd;
      rxd_s_q <= sync1_q;
    end

  // bus address phase; the slave never stalls and always answers okay
  logic       acc_rd;
  logic       acc_wr;
  logic [7:0] ofs;
  logic       wr_pend_q;
  logic [7:0] wr_ofs_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ofs       = haddr[7:0];
  assign acc_rd    = hsel & htrans[1] & hready & ~hwrite;
  assign acc_wr    = hsel & htrans[1] & hready & hwrite;

  logic rd_status;
  logic rd_buf;
  assign rd_status = acc_rd & (ofs == `OFS_LINE_STATUS);
  assign rd_buf    = acc_rd & (ofs == `OFS_RX_BUF);

  // software registers, written in the data phase from hwdata
  logic [7:0]  line_ctrl_q, line_ctrl_d;
  logic        fifo_ena_q, fifo_ena_d;
  logic        fifo_rst;
  logic [15:0] baud_div_q, baud_div_d;
  always_comb
  begin
    line_ctrl_d = line_ctrl_q;
    fifo_ena_d  = fifo_ena_q;
    baud_div_d  = baud_div_q;
    fifo_rst    = 1'b0;
    if (wr_pend_q)
    begin
      case (wr_ofs_q)
        `OFS_LINE_CTRL: line_ctrl_d = hwdata[7:0];
        `OFS_BAUD_DIV:  baud_div_d  = hwdata[15:0];
        `OFS_FIFO_CTRL:
        begin
          fifo_ena_d = hwdata[`FC_ENA_BIT];
          // a mode change flushes, so no stale depth survives into one-deep mode
          fifo_rst   = hwdata[`FC_RX_RST_BIT] |
                       (hwdata[`FC_ENA_BIT] != fifo_ena_q);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      wr_pend_q   <= 1'b0;
      wr_ofs_q    <= 8'h00;
      line_ctrl_q <= `LINE_CTRL_RST;
      fifo_ena_q  <= `FIFO_CTRL_RST;
      baud_div_q  <= `BAUD_DIV_RST;
    end
    else
    begin
      wr_pend_q   <= acc_wr;
      wr_ofs_q    <= ofs;
      line_ctrl_q <= line_ctrl_d;
      fifo_ena_q  <= fifo_ena_d;
      baud_div_q  <= baud_div_d;
    end

  // receiver state machine, samples each bit in its middle
  rx_state_t   st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  shf_q, shf_d;
  logic        par_q, par_d;
  logic        zero_q, zero_d;
  logic        rx_done;
  logic        rx_brk;
  logic        rx_par_err;
  logic [7:0]  rx_char;
  logic [2:0]  last_bit;
  logic        tick;
  assign last_bit = 3'd4 + {1'b0, line_ctrl_q[`LC_WLEN_LSB +: 2]};
  assign tick     = (cnt_q == 16'h0000);

  always_comb
  begin
    st_d       = st_q;
    cnt_d      = tick ? 16'h0000 : cnt_q - 16'h0001;
    bit_d      = bit_q;
    shf_d      = shf_q;
    par_d      = par_q;
    zero_d     = zero_q;
    rx_done    = 1'b0;
    rx_brk     = 1'b0;
    rx_par_err = 1'b0;
    rx_char    = shf_q >> (3'd7 - last_bit);
    case (st_q)
      RX_IDLE:
        if (!rxd_s_q)
        begin
          st_d  = RX_START;
          cnt_d = baud_div_q >> 1;
        end
      RX_START:
        if (tick)
        begin
          st_d   = rxd_s_q ? RX_IDLE : RX_DATA;
          cnt_d  = baud_div_q - 16'h0001;
          bit_d  = 3'd0;
          shf_d  = 8'h00;
          par_d  = 1'b0;
          zero_d = 1'b1;
        end
      RX_DATA:
        if (tick)
        begin
          shf_d  = {rxd_s_q, shf_q[7:1]};
          par_d  = par_q ^ rxd_s_q;
          zero_d = zero_q & ~rxd_s_q;
          bit_d  = bit_q + 3'd1;
          cnt_d  = baud_div_q - 16'h0001;
          if (bit_q == last_bit)
            st_d = line_ctrl_q[`LC_PAR_ENA_BIT] ? RX_PAR : RX_STOP;
        end
      RX_PAR:
        if (tick)
        begin
          par_d  = par_q ^ rxd_s_q;
          zero_d = zero_q & ~rxd_s_q;
          cnt_d  = baud_div_q - 16'h0001;
          st_d   = RX_STOP;
        end
      RX_STOP:
        if (tick)
        begin
          rx_done = 1'b1;
          // low through start, data, parity and stop: a break
          rx_brk  = zero_q & ~rxd_s_q; // [R11]
          // even parity wants a zero sum, odd a one
          rx_par_err = (line_ctrl_q[`LC_PAR_ENA_BIT] &
                        (par_q ^ ~line_ctrl_q[`LC_EVEN_BIT])) | rx_brk; // [R01] [R03]
          if (rx_brk)
            rx_char = 8'h00; // [R11]
          // after a break wait for the line to rise: one character only
          st_d = rx_brk ? RX_BRKW : RX_IDLE; // [R11]
        end
      RX_BRKW:
        if (rxd_s_q)
          st_d = RX_IDLE;
      default:
        st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      st_q   <= RX_IDLE;
      cnt_q  <= 16'h0000;
      bit_q  <= 3'd0;
      shf_q  <= 8'h00;
      par_q  <= 1'b0;
      zero_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      bit_q  <= bit_d;
      shf_q  <= shf_d;
      par_q  <= par_d;
      zero_q <= zero_d;
    end

  // receive store: DEPTH entries in fifo mode, one in buffer mode
  rx_entry_t   mem [DEPTH];
  rx_entry_t   rx_in;
  rx_entry_t   head_new;
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d, wa, rd_next;
  logic [CW-1:0] cnt_f_q, cnt_f_d, limit;
  logic        pop, push, ovr, we, head_chg;
  assign rx_in   = '{brk: rx_brk, par_err: rx_par_err, data: rx_char};
  assign limit   = fifo_ena_q ? CW'(DEPTH) : CW'(1);
  assign pop     = rd_buf & (cnt_f_q != '0);
  assign rd_next = rd_q + AW'(1);

  always_comb
  begin
    rd_d     = pop ? rd_next : rd_q;
    wr_d     = wr_q;
    cnt_f_d  = cnt_f_q - CW'(pop);
    wa       = wr_q;
    we       = 1'b0;
    ovr      = rx_done & ~pop & (cnt_f_q >= limit);
    push     = rx_done & ~ovr;
    head_chg = 1'b0;
    head_new = rx_in;
    if (ovr && !fifo_ena_q)
    begin
      // buffer mode: the unread character is overwritten
      wa       = rd_q; // [R05]
      we       = 1'b1;
      head_chg = 1'b1;
    end
    else if (push)
    begin
      we      = 1'b1;
      wr_d    = wr_q + AW'(1);
      cnt_f_d = cnt_f_q - CW'(pop) + CW'(1);
    end
    // flags follow the character that becomes the head
    if (pop && cnt_f_q > CW'(1))
    begin
      head_chg = 1'b1; // [R02]
      head_new = mem[rd_next];
    end
    else if (push && (cnt_f_q == '0 || pop))
      head_chg = 1'b1; // [R02]
    if (fifo_rst)
    begin
      rd_d     = '0;
      wr_d     = '0;
      cnt_f_d  = '0;
      we       = 1'b0;
      head_chg = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      rd_q    <= '0;
      wr_q    <= '0;
      cnt_f_q <= '0;
    end
    else
    begin
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      cnt_f_q <= cnt_f_d;
    end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk_sys)
    if (we)
      mem[wa] <= rx_in;

  // sticky status: a set in the clearing cycle wins
  logic par_flag_q, par_flag_d;
  logic ovr_flag_q, ovr_flag_d;
  logic brk_flag_q, brk_flag_d;
  always_comb
  begin
    par_flag_d = (par_flag_q & ~rd_status) |
                 (head_chg & head_new.par_err); // [R04] [R12] [R02]
    ovr_flag_d = (ovr_flag_q & ~rd_status) | ovr; // [R05] [R06] [R07] [R12]
    brk_flag_d = (brk_flag_q & ~rd_status) | (head_chg & head_new.brk);
  end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      par_flag_q <= 1'b0;
      ovr_flag_q <= 1'b0;
      brk_flag_q <= 1'b0;
    end
    else
    begin
      par_flag_q <= par_flag_d;
      ovr_flag_q <= ovr_flag_d;
      brk_flag_q <= brk_flag_d;
    end

  // level from the stored count: covers both the buffer and fifo cases
  assign rx_data_available = (cnt_f_q != '0); // [R08] [R09] [R10]

  // read data captured at the address phase, values before any clearing
  logic [31:0] rdata_d;
  logic [31:0] hrdata_q;
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (ofs)
      `OFS_RX_BUF:
        rdata_d[7:0] = (cnt_f_q != '0) ? mem[rd_q].data : 8'h00;
      `OFS_LINE_CTRL:   rdata_d[7:0] = line_ctrl_q;
      `OFS_FIFO_CTRL:   rdata_d[`FC_ENA_BIT] = fifo_ena_q;
      `OFS_BAUD_DIV:    rdata_d[15:0] = baud_div_q;
      `OFS_LINE_STATUS:
      begin
        rdata_d[`LS_AVAIL_BIT]   = rx_data_available;
        rdata_d[`LS_OVERRUN_BIT] = ovr_flag_q;
        rdata_d[`LS_PAR_ERR_BIT] = par_flag_q;
        rdata_d[`LS_BREAK_BIT]   = brk_flag_q;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      hrdata_q <= 32'h0000_0000;
    else if (acc_rd)
      hrdata_q <= rdata_d;
  assign hrdata = hrdata_q;

  // checks
  par_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R01]
    rx_done && !line_ctrl_q[`LC_PAR_ENA_BIT] && !rx_brk && !par_flag_q
    && cnt_f_q == '0 |=> !par_flag_q)
    else $error("parity flag set while parity off");
  par_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R02]
    fifo_ena_q && push && cnt_f_q != '0 && !pop && !par_flag_q
    |=> !par_flag_q)
    else $error("parity flag shown before head");
  brk_par_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R03]
    head_chg && head_new.brk |=> par_flag_q && brk_flag_q)
    else $error("break without parity flag");
  par_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R04]
    rd_status && !head_chg |=> !par_flag_q)
    else $error("parity flag survived status read");
  ovr_buf_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R05]
    rx_done && !fifo_ena_q && cnt_f_q == CW'(1) && !pop && !fifo_rst
    |=> ovr_flag_q && cnt_f_q == CW'(1) && mem[rd_q].data == $past(rx_char))
    else $error("buffer overrun not handled");
  ovr_fifo_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R06]
    rx_done && fifo_ena_q && cnt_f_q == CW'(DEPTH) && !pop && !fifo_rst
    |=> ovr_flag_q && $stable(cnt_f_q) && $stable(wr_q))
    else $error("fifo overrun not handled");
  ovr_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R07]
    rd_status && !ovr |=> !ovr_flag_q)
    else $error("overrun flag survived status read");
  avail_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R08]
    push && !fifo_rst |=> rx_data_available [*1] ##1 1'b1)
    else $error("data available missing after receive");
  avail_buf_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R09]
    !fifo_ena_q && pop && !rx_done |=> !rx_data_available)
    else $error("data available not cleared by read");
  avail_fifo_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R10]
    fifo_ena_q && pop && cnt_f_q > CW'(1) && !fifo_rst
    |=> rx_data_available)
    else $error("data available cleared too early");
  brk_char_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R11]
    rx_done && rx_brk |-> rx_char == 8'h00 ##1 st_q == RX_BRKW)
    else $error("break character wrong");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R12]
    rd_status && ovr |=> ovr_flag_q)
    else $error("overrun lost on clearing read");

endmodule

// ### pkg/uart_rx_pkg.sv
// types shared by the receive status block
package uart_rx_pkg;

  typedef enum logic [2:0]
  {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100,
    RX_BRKW  = 3'b101
  } rx_state_t;

  // one fifo entry: break mark, parity error mark, character
  typedef struct packed
  {
    logic       brk;
    logic       par_err;
    logic [7:0] data;
  } rx_entry_t;

endpackage

// ### pkg/uart_rx_regs.svh
// register offsets, field positions, reset values and counts of the receiver
// Contract
// [R01] parity error flag set only for failing characters while parity is on; the code also sets it for a break with parity off
// [R02] fifo mode: parity error shows only when its character reaches the head
// [R03] a detected break also raises the parity error flag for that character
// [R04] reading line status clears the parity error flag
// [R05] no fifo: new character over unread one sets overrun, overwrites buffer
// [R06] fifo full: new character sets overrun, fifo kept, new one dropped
// [R07] reading line status clears the overrun flag
// [R08] data available is high exactly while a received character waits
// [R09] no fifo: reading the receive buffer clears data available
// [R10] fifo mode: data available clears only once the fifo is empty
// [R11] line low over a whole character is a break; one zero character kept
// [R12] an error in the same cycle as a clearing read stays set
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH

`define OFS_RX_BUF      8'h00
`define OFS_FIFO_CTRL   8'h08
`define OFS_LINE_CTRL   8'h0C
`define OFS_LINE_STATUS 8'h14
`define OFS_BAUD_DIV    8'h20

// line_control_reg fields
`define LC_WLEN_LSB     0
`define LC_PAR_ENA_BIT  3
`define LC_EVEN_BIT     4
// fifo control fields
`define FC_ENA_BIT      0
`define FC_RX_RST_BIT   1
// line_status_reg fields
`define LS_AVAIL_BIT    0
`define LS_OVERRUN_BIT  1
`define LS_PAR_ERR_BIT  2
`define LS_BREAK_BIT    4

`define LINE_CTRL_RST   8'h03
`define FIFO_CTRL_RST   1'h0
// 200 MHz / 115200 baud, in clock cycles per bit
`define BAUD_DIV_RST    16'h06C8
`define RX_FIFO_DEPTH   16

`endif

// ### test/serial_tx_model.sv
// remote serial transmitter that drives the receive line
`timescale 1ns/1ps

module serial_tx_model
#(
  parameter int DIV = 16
)
(
  input  wire logic clk_sys,
  output logic      rxd
);
  // line rests high between frames
  initial rxd = 1'b1;

  // one bit cell lasts DIV clock cycles
  task automatic bit_out(input logic b);
    @(posedge clk_sys);
    rxd <= b;
    repeat (DIV - 1) @(posedge clk_sys);
  endtask

  // lsb first, optional parity, stop then one idle cell
  task automatic send(input logic [7:0] d, input logic par_on,
                      input logic par_bit);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++)
      bit_out(d[i]);
    if (par_on)
      bit_out(par_bit);
    bit_out(1'b1);
    bit_out(1'b1);
  endtask

  // low for more than a full character, then idle again
  task automatic send_break();
    bit_out(1'b0);
    repeat (12 * DIV) @(posedge clk_sys);
    bit_out(1'b1);
    bit_out(1'b1);
  endtask
endmodule

// ### test/uart_rx_line_status_flags_tb.sv
// self-checking bench for the receive status flags
`timescale 1ns/1ps
`include "uart_rx_regs.svh"

module uart_rx_line_status_flags_tb;
  logic        clk_sys;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        rxd;
  logic        rx_data_available;
  int          bad_count;
  int          check_count;
  logic [31:0] rd;

  // small fifo so that a full fifo is cheap to reach
  uart_rx_status #(.DEPTH(2)) i_dut
  (
    .clk_sys           (clk_sys),
    .rst_b             (rst_b),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hreadyout         (hreadyout),
    .hrdata            (hrdata),
    .hresp             (hresp),
    .rxd               (rxd),
    .rx_data_available (rx_data_available)
  );

  serial_tx_model #(.DIV(16)) i_tx
  (
    .clk_sys (clk_sys),
    .rxd     (rxd)
  );

  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      bad_count++;
      stop_test();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic status_is(input logic [31:0] e);
    bus(1'b0, `OFS_LINE_STATUS, 32'h0, rd);
    chk("line_status_reg", e, rd);
  endtask

  task automatic buffer_is(input logic [7:0] e);
    bus(1'b0, `OFS_RX_BUF, 32'h0, rd);
    chk("receive_buffer", {24'h0, e}, rd);
  endtask

  // parity error only with parity on, cleared by a status read
  task automatic t_parity();
    status_is(32'h0);
    wr(`OFS_LINE_CTRL, 32'h3);
    i_tx.send(8'hA5, 1'b0, 1'b0);
    chk("avail", 32'h1, {31'h0, rx_data_available});
    status_is(32'h1);
    buffer_is(8'hA5);
    // even parity: four ones and a zero parity bit are a good character
    wr(`OFS_LINE_CTRL, 32'h1B);
    i_tx.send(8'hA5, 1'b1, 1'b0);
    status_is(32'h1);
    buffer_is(8'hA5);
    wr(`OFS_LINE_CTRL, 32'hB);
    i_tx.send(8'hA5, 1'b1, 1'b0);
    status_is(32'h5);
    status_is(32'h1);
    buffer_is(8'hA5);
    status_is(32'h0);
  endtask

  // unbuffered: second character overwrites the unread first
  task automatic t_overrun_buf();
    i_tx.send(8'h3C, 1'b1, 1'b1);
    i_tx.send(8'h5A, 1'b1, 1'b1);
    status_is(32'h3);
    status_is(32'h1);
    buffer_is(8'h5A);
  endtask

  // status reads land on every phase of the overrun cycle; the overrun
  // must show exactly once, so a set lost to a clearing read is caught
  task automatic t_clear_race();
    int seen;
    for (int k = 0; k < 3; k++)
    begin
      seen = 0;
      i_tx.send(8'h3C, 1'b1, 1'b1);
      fork
        i_tx.send(8'h5A, 1'b1, 1'b1);
        begin
          repeat (k) @(posedge clk_sys);
          repeat (70)
          begin
            bus(1'b0, `OFS_LINE_STATUS, 32'h0, rd);
            seen += int'(rd[`LS_OVERRUN_BIT]);
          end
        end
      join
      chk("overrun reads", 32'h1, seen);
      status_is(32'h1);
      buffer_is(8'h5A);
    end
  endtask

  // fifo: error revealed at the head, ready clears on empty
  task automatic t_fifo();
    wr(`OFS_FIFO_CTRL, 32'h1);
    i_tx.send(8'h11, 1'b1, 1'b1);
    i_tx.send(8'h22, 1'b1, 1'b0);
    status_is(32'h1);
    buffer_is(8'h11);
    status_is(32'h5);
    buffer_is(8'h22);
    status_is(32'h0);
  endtask

  // fifo full: third character dropped, contents kept
  task automatic t_overrun_fifo();
    i_tx.send(8'h01, 1'b1, 1'b0);
    i_tx.send(8'h02, 1'b1, 1'b0);
    i_tx.send(8'h03, 1'b1, 1'b0);
    status_is(32'h3);
    buffer_is(8'h01);
    status_is(32'h1);
    buffer_is(8'h02);
    status_is(32'h0);
  endtask

  // break yields one zero character with parity and break marks
  task automatic t_break();
    i_tx.send_break();
    status_is(32'h15);
    buffer_is(8'h00);
    status_is(32'h0);
  endtask

  // a hang is cut short here, well inside the cycle budget
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end

  initial
  begin
    bad_count = 0;
    check_count = 0;
    rst_b  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(`OFS_BAUD_DIV, 32'h10);
    t_parity();
    t_overrun_buf();
    t_clear_race();
    t_fifo();
    t_overrun_fifo();
    t_break();
    stop_test();
  end
endmodule
